/* File: src/login_pkg.sv */
`default_nettype none
package login_pkg;
  // register offsets, one aligned word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOCAL_W1 = 8'h04;
  localparam logic [7:0] ADDR_PEER_W1 = 8'h08;
  localparam logic [7:0] ADDR_PEER_W2 = 8'h0C;
  localparam logic [7:0] ADDR_PEER_W3 = 8'h10;
  localparam logic [7:0] ADDR_COMMON = 8'h14;
  localparam logic [7:0] ADDR_AUX_W0 = 8'h18;
  localparam logic [7:0] ADDR_AUX_W3 = 8'h1C;
  localparam logic [7:0] ADDR_VV0 = 8'h20;
  localparam logic [7:0] ADDR_VV3 = 8'h2C;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_LIMITS = 8'h34;
  localparam logic [7:0] ADDR_SIZES = 8'h38;
  localparam logic [7:0] ADDR_NPIV = 8'h3C;
  localparam logic [7:0] ADDR_CREDIT = 8'h40;
  localparam logic [2:0] WORD_SIZE = 3'h2;
  // control and credit command bits
  localparam int CTRL_CLASS3 = 3;
  localparam int CTRL_PROCESS = 4;
  localparam int CTRL_CAPTURE = 5;
  localparam int CMD_SEND = 0;
  localparam int CMD_ACK = 1;
  localparam int CMD_CLEAR = 2;
  localparam int CMD_CAT_LO = 4;
  // service parameter field positions
  localparam int EP_HI = 28;
  localparam int EP_LO = 27;
  localparam int CAT_HI = 25;
  localparam int CAT_LO = 24;
  localparam int CLKSYNC_BIT = 19;
  localparam int SCOPE_BIT = 18;
  localparam int RX_HI = 11;
  localparam int CONC_HI = 23;
  localparam int CONC_LO = 16;
  localparam int E2E_TOP = 15;
  localparam int OPEN_HI = 23;
  localparam int OPEN_LO = 16;
  localparam int AUX_ZERO_BIT = 31;
  localparam int VV_BIT = 29;
  // field codes and limits
  localparam logic [1:0] EP_DISCARD = 2'h0;
  localparam logic [1:0] EP_BOTH = 2'h2;
  localparam logic [1:0] CAT_ONE = 2'h0;
  localparam logic [1:0] CAT_TWO = 2'h1;
  localparam logic [1:0] CAT_RSVD = 2'h2;
  localparam logic [1:0] CAT_MANY = 2'h3;
  localparam logic [11:0] RX_MIN = 12'h100;
  localparam logic [11:0] RX_MAX = 12'h840;
  localparam logic [8:0] SSB_EXTRA = 9'h002;
  localparam logic [15:0] NPIV_MAX_CNT = 16'hFFFD;
  localparam logic [15:0] NPIV_MORE = 16'hFFFE;
  localparam logic [1:0] NPIV_NONE = 2'h0;
  localparam logic [1:0] NPIV_COUNT = 2'h1;
  localparam logic [1:0] NPIV_ABOVE = 2'h2;
  localparam logic [1:0] NPIV_UNKNOWN = 2'h3;

  typedef enum logic [2:0] {
    LT_PLOGI_REQ = 3'b000,
    LT_PLOGI_ACC = 3'b001,
    LT_FLOGI_REQ = 3'b010,
    LT_FLOGI_ACC = 3'b011,
    LT_FDISC_REQ = 3'b100,
    LT_FDISC_ACC = 3'b101
  } login_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_e;

  // layout of the status register
  typedef struct packed {
    logic [7:0] spare;
    logic [1:0] cat_c3;
    logic [1:0] cat_c2;
    logic [1:0] npiv_kind;
    logic vv_valid;
    logic aux_bad;
    logic e2e_bad;
    logic conc_bad;
    logic rx_class_bad;
    logic rx_bad;
    logic cat_bad;
    logic ep_bad;
    logic [1:0] cat_code;
    logic [2:0] pad;
    logic invalid;
    logic clk_sync;
    logic scope_per_x;
    logic use_process;
    logic ep_both;
  } status_s;

  function automatic logic cat_fits(input logic [1:0] need,
                                    input logic [1:0] cap);
    return (cap == CAT_MANY) || (need == CAT_ONE) ||
           (need == CAT_TWO && cap == CAT_TWO);
  endfunction
endpackage
`default_nettype wire

/* File: src/login_field_decoder.sv */
`default_nettype none
module login_field_decoder (
  input wire logic [31:0] local_w1,
  input wire logic [31:0] peer_w1,
  input wire logic [31:0] peer_w2,
  input wire logic [31:0] peer_w3,
  input wire logic [31:0] common_w,
  input wire logic [31:0] aux_w0,
  input wire logic [31:0] aux_w3,
  input wire login_pkg::login_e login_type,
  input wire logic class3,
  input wire logic want_process,
  output login_pkg::status_s status,
  output logic [11:0] rx_size,
  output logic [7:0] conc,
  output logic [15:0] e2e,
  output logic [7:0] open_seq,
  output logic [8:0] ssb_cnt,
  output logic [15:0] npiv_cnt
);
  always_comb
  begin
    status = '0;
    status.ep_both = peer_w1[login_pkg::EP_HI:login_pkg::EP_LO]
                     == login_pkg::EP_BOTH;
    status.ep_bad = !status.ep_both &&
                    peer_w1[login_pkg::EP_HI:login_pkg::EP_LO]
                    != login_pkg::EP_DISCARD;
    status.use_process = want_process && status.ep_both;
    status.cat_code = peer_w1[login_pkg::CAT_HI:login_pkg::CAT_LO];
    status.cat_bad = status.cat_code == login_pkg::CAT_RSVD;
    status.clk_sync = peer_w1[login_pkg::CLKSYNC_BIT];
    status.scope_per_x = local_w1[login_pkg::SCOPE_BIT] &&
                         peer_w1[login_pkg::SCOPE_BIT];
    rx_size = peer_w1[login_pkg::RX_HI:0];
    status.rx_bad = rx_size < login_pkg::RX_MIN ||
                    rx_size > login_pkg::RX_MAX || rx_size[1:0] != 2'h0;
    status.rx_class_bad = rx_size > common_w[login_pkg::RX_HI:0];
    conc = peer_w2[login_pkg::CONC_HI:login_pkg::CONC_LO];
    status.conc_bad = conc == 8'h00;
    // credit encoding, ignored for class 3
    e2e = peer_w2[15:0];
    status.e2e_bad = !class3 &&
                     (e2e[login_pkg::E2E_TOP] || e2e[14:0] == 15'h0000);
    // open sequences only in port login
    open_seq = 8'h00;
    if (login_type == login_pkg::LT_PLOGI_REQ ||
        login_type == login_pkg::LT_PLOGI_ACC)
      open_seq = peer_w3[login_pkg::OPEN_HI:login_pkg::OPEN_LO];
    ssb_cnt = {1'b0, open_seq} + login_pkg::SSB_EXTRA;
    // top flag bit must be clear
    status.aux_bad = aux_w0[login_pkg::AUX_ZERO_BIT];
    npiv_cnt = 16'h0000;
    status.npiv_kind = login_pkg::NPIV_NONE;
    unique case (login_type)
      login_pkg::LT_FLOGI_ACC, login_pkg::LT_FDISC_ACC:
      begin
        npiv_cnt = aux_w3[15:0];
        if (npiv_cnt <= login_pkg::NPIV_MAX_CNT)
          status.npiv_kind = login_pkg::NPIV_COUNT;
        else if (npiv_cnt == login_pkg::NPIV_MORE)
          status.npiv_kind = login_pkg::NPIV_ABOVE;
        else
          status.npiv_kind = login_pkg::NPIV_UNKNOWN;
      end
      // advisory only, never a limit
      login_pkg::LT_FLOGI_REQ:
        npiv_cnt = aux_w3[15:0];
      default:
        npiv_cnt = 16'h0000;
    endcase
    status.vv_valid = common_w[login_pkg::VV_BIT];
    // any bad field flags the login
    status.invalid = status.ep_bad || status.cat_bad || status.rx_bad ||
                     status.rx_class_bad || status.conc_bad ||
                     status.e2e_bad || status.aux_bad;
  end
endmodule
`default_nettype wire

/* File: src/credit_window.sv */
`default_nettype none
module credit_window (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [14:0] limit,
  input wire logic class3,
  input wire logic [1:0] cat_need,
  input wire logic [1:0] cat_cap,
  input wire logic send,
  input wire logic ack,
  input wire logic clear,
  output logic grant,
  output logic refuse,
  output logic [15:0] outstanding,
  output logic [7:0] seq_id
);
  typedef struct packed {
    logic [15:0] outstanding;
    logic [7:0] seq_id;
    logic grant;
    logic refuse;
  } credit_s;

  credit_s s;
  credit_s next_s;
  logic room;
  logic cat_ok;

  always_comb
  begin
    next_s = s;
    next_s.grant = 1'b0;
    next_s.refuse = 1'b0;
    // window closes at the advertised credit; class 3 has no acks
    room = class3 || s.outstanding < {1'b0, limit};
    cat_ok = login_pkg::cat_fits(cat_need, cat_cap);
    if (clear)
      next_s.outstanding = 16'h0000;
    else
    begin
      if (ack && s.outstanding != 16'h0000)
        next_s.outstanding = s.outstanding - 16'h0001;
      if (send && room && cat_ok)
      begin
        next_s.grant = 1'b1;
        // eight-bit identifier stays within 0 to 255
        next_s.seq_id = s.seq_id + 8'h01;
        if (!class3)
          next_s.outstanding = next_s.outstanding + 16'h0001;
      end
      else if (send)
        next_s.refuse = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign grant = s.grant;
  assign refuse = s.refuse;
  assign outstanding = s.outstanding;
  assign seq_id = s.seq_id;

  a_credit_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    send && !clear && !class3 && s.outstanding >= {1'b0, limit} |=>
      refuse && !grant)
    else $error("credit window overrun");
  a_cat_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    send && !clear && !login_pkg::cat_fits(cat_need, cat_cap) |=> refuse)
    else $error("category limit not enforced");
  a_seq_step: assert property (@(posedge hclk) disable iff (!hresetn)
    grant |-> seq_id == $past(seq_id) + 8'h01)
    else $error("sequence id step wrong");
  c_refuse: cover property (@(posedge hclk) disable iff (!hresetn) refuse);
  c_full: cover property (@(posedge hclk) disable iff (!hresetn)
    !class3 && s.outstanding == {1'b0, limit} && send);
endmodule
`default_nettype wire

/* File: src/login_param_host.sv */
`default_nettype none
module login_param_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic login_reject
);
  typedef struct packed {
    login_pkg::bus_e bus;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic login_reject;
    login_pkg::login_e login_type;
    logic class3;
    logic want_process;
    logic [31:0] local_w1;
    logic [31:0] peer_w1;
    logic [31:0] peer_w2;
    logic [31:0] peer_w3;
    logic [31:0] common_w;
    logic [31:0] aux_w0;
    logic [31:0] aux_w3;
    logic [3:0][31:0] vv;
    logic [1:0] cat_c2;
    logic [1:0] cat_c3;
    logic [1:0] cat_need;
    logic send;
    logic ack;
    logic clear;
    logic last_grant;
    logic last_refuse;
    login_pkg::status_s st;
    logic [11:0] rx_size;
    logic [7:0] conc;
    logic [15:0] e2e;
    logic [7:0] open_seq;
    logic [8:0] ssb_cnt;
    logic [15:0] npiv_cnt;
  } host_state_s;

  host_state_s s;
  host_state_s next_s;
  login_pkg::status_s d_status;
  logic [11:0] d_rx_size;
  logic [7:0] d_conc;
  logic [15:0] d_e2e;
  logic [7:0] d_open_seq;
  logic [8:0] d_ssb_cnt;
  logic [15:0] d_npiv_cnt;
  logic grant;
  logic refuse;
  logic [15:0] outstanding;
  logic [7:0] seq_id;
  logic take;

  login_field_decoder dec (
    .local_w1(s.local_w1),
    .peer_w1(s.peer_w1),
    .peer_w2(s.peer_w2),
    .peer_w3(s.peer_w3),
    .common_w(s.common_w),
    .aux_w0(s.aux_w0),
    .aux_w3(s.aux_w3),
    .login_type(s.login_type),
    .class3(s.class3),
    .want_process(s.want_process),
    .status(d_status),
    .rx_size(d_rx_size),
    .conc(d_conc),
    .e2e(d_e2e),
    .open_seq(d_open_seq),
    .ssb_cnt(d_ssb_cnt),
    .npiv_cnt(d_npiv_cnt)
  );

  credit_window credit (
    .hclk(hclk),
    .hresetn(hresetn),
    .limit(s.e2e[14:0]),
    .class3(s.class3),
    .cat_need(s.cat_need),
    .cat_cap(s.class3 ? s.cat_c3 : s.cat_c2),
    .send(s.send),
    .ack(s.ack),
    .clear(s.clear),
    .grant(grant),
    .refuse(refuse),
    .outstanding(outstanding),
    .seq_id(seq_id)
  );

  // only whole-word transfers are taken; others pass as idle
  assign take = hsel && htrans[1] && hready && hsize == login_pkg::WORD_SIZE;

  always_comb
  begin
    next_s = s;
    next_s.send = 1'b0;
    next_s.ack = 1'b0;
    next_s.clear = 1'b0;
    // decoded fields are registered so reads see stable values
    next_s.st = d_status;
    next_s.st.cat_c2 = s.cat_c2;
    next_s.st.cat_c3 = s.cat_c3;
    next_s.rx_size = d_rx_size;
    next_s.conc = d_conc;
    next_s.e2e = d_e2e;
    next_s.open_seq = d_open_seq;
    next_s.ssb_cnt = d_ssb_cnt;
    next_s.npiv_cnt = d_npiv_cnt;
    next_s.login_reject = s.st.invalid;
    unique case (s.bus)
      login_pkg::BUS_IDLE:
        next_s.bus = login_pkg::BUS_IDLE;
      login_pkg::BUS_WRITE:
      begin
        next_s.bus = login_pkg::BUS_IDLE;
        unique case (s.addr)
          login_pkg::ADDR_CTRL:
          begin
            next_s.login_type = login_pkg::login_e'(hwdata[2:0]);
            next_s.class3 = hwdata[login_pkg::CTRL_CLASS3];
            next_s.want_process = hwdata[login_pkg::CTRL_PROCESS];
            if (hwdata[login_pkg::CTRL_CAPTURE])
            begin
              next_s.clear = 1'b1;
              if (hwdata[login_pkg::CTRL_CLASS3])
                next_s.cat_c3 = s.st.cat_code;
              else
                next_s.cat_c2 = s.st.cat_code;
            end
          end
          login_pkg::ADDR_LOCAL_W1: next_s.local_w1 = hwdata;
          login_pkg::ADDR_PEER_W1: next_s.peer_w1 = hwdata;
          login_pkg::ADDR_PEER_W2: next_s.peer_w2 = hwdata;
          login_pkg::ADDR_PEER_W3: next_s.peer_w3 = hwdata;
          login_pkg::ADDR_COMMON: next_s.common_w = hwdata;
          login_pkg::ADDR_AUX_W0: next_s.aux_w0 = hwdata;
          login_pkg::ADDR_AUX_W3: next_s.aux_w3 = hwdata;
          login_pkg::ADDR_CREDIT:
          begin
            next_s.send = hwdata[login_pkg::CMD_SEND];
            next_s.ack = hwdata[login_pkg::CMD_ACK];
            next_s.clear = hwdata[login_pkg::CMD_CLEAR];
            next_s.cat_need = hwdata[login_pkg::CMD_CAT_LO +: 2];
            // a new command forgets the previous outcome
            next_s.last_grant = 1'b0;
            next_s.last_refuse = 1'b0;
          end
          default:
            if (s.addr >= login_pkg::ADDR_VV0 &&
                s.addr <= login_pkg::ADDR_VV3)
              next_s.vv[s.addr[3:2]] = hwdata;
        endcase
      end
      login_pkg::BUS_READ:
      begin
        next_s.bus = login_pkg::BUS_IDLE;
        next_s.hreadyout = 1'b1;
        unique case (s.addr)
          login_pkg::ADDR_CTRL:
            next_s.hrdata = {26'h000_0000, 1'b0, s.want_process,
                             s.class3, s.login_type};
          login_pkg::ADDR_LOCAL_W1: next_s.hrdata = s.local_w1;
          login_pkg::ADDR_PEER_W1: next_s.hrdata = s.peer_w1;
          login_pkg::ADDR_PEER_W2: next_s.hrdata = s.peer_w2;
          login_pkg::ADDR_PEER_W3: next_s.hrdata = s.peer_w3;
          login_pkg::ADDR_COMMON: next_s.hrdata = s.common_w;
          login_pkg::ADDR_AUX_W0: next_s.hrdata = s.aux_w0;
          login_pkg::ADDR_AUX_W3: next_s.hrdata = s.aux_w3;
          login_pkg::ADDR_STATUS: next_s.hrdata = s.st;
          login_pkg::ADDR_LIMITS:
            next_s.hrdata = {s.conc, s.open_seq, s.e2e};
          login_pkg::ADDR_SIZES:
            next_s.hrdata = {7'h00, s.ssb_cnt, 4'h0, s.rx_size};
          login_pkg::ADDR_NPIV: next_s.hrdata = {16'h0000, s.npiv_cnt};
          login_pkg::ADDR_CREDIT:
            next_s.hrdata = {s.last_refuse, s.last_grant, 6'h00,
                             seq_id, outstanding};
          default:
          begin
            next_s.hrdata = 32'h0000_0000;
            // vendor words read as zero unless flagged valid
            if (s.addr >= login_pkg::ADDR_VV0 &&
                s.addr <= login_pkg::ADDR_VV3 && s.st.vv_valid)
              next_s.hrdata = s.vv[s.addr[3:2]];
          end
        endcase
      end
      default:
        next_s.bus = login_pkg::BUS_IDLE;
    endcase
    // a new outcome beats the forgetting by a command write
    if (grant)
      next_s.last_grant = 1'b1;
    if (refuse)
      next_s.last_refuse = 1'b1;
    // reads insert one wait state so the answer comes from a flop
    if (s.bus != login_pkg::BUS_READ && take)
    begin
      next_s.addr = haddr[7:0];
      if (hwrite)
        next_s.bus = login_pkg::BUS_WRITE;
      else
      begin
        next_s.bus = login_pkg::BUS_READ;
        next_s.hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign login_reject = s.login_reject;

  a_policy_choice: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st.use_process ==
      ($past(s.want_process) && $past(s.peer_w1[28:27]) == 2'h2))
    else $error("process chosen without peer support");
  a_policy_code: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st.ep_both == ($past(s.peer_w1[28:27]) == 2'h2))
    else $error("error policy decode wrong");
  a_cat_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    s.peer_w1[25:24] == 2'h2 |=> s.st.cat_bad)
    else $error("reserved category code missed");
  a_seq_scope: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st.scope_per_x == ($past(s.local_w1[18]) && $past(s.peer_w1[18])))
    else $error("identifier scope wrong");
  a_rx_range: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.peer_w1[11:0] < 12'h100 || s.peer_w1[11:0] > 12'h840 ||
     s.peer_w1[1:0] != 2'h0) |=> s.st.rx_bad)
    else $error("bad receive size not flagged");
  a_conc_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    s.peer_w2[23:16] == 8'h00 |=> s.st.conc_bad)
    else $error("zero concurrent sequences not flagged");
  a_e2e_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.class3 && s.peer_w2[14:0] == 15'h0000 ##1 !s.class3 |-> s.st.e2e_bad)
    else $error("zero credit not flagged");
  a_reject_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st.invalid |=> login_reject)
    else $error("invalid login not rejected");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    !hreadyout |=> hreadyout)
    else $error("read wait longer than one cycle");
  c_grant: cover property (@(posedge hclk) disable iff (!hresetn) grant);
  c_reject: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(login_reject));
  c_read: cover property (@(posedge hclk) disable iff (!hresetn)
    s.bus == login_pkg::BUS_READ);
endmodule
`default_nettype wire

/* File: bench/peer_port.sv */
`default_nettype none
module peer_port (
  input wire logic [1:0] ep,
  input wire logic [1:0] cat,
  input wire logic [11:0] rx,
  input wire logic [7:0] conc,
  input wire logic [15:0] e2e,
  input wire logic [7:0] openx,
  output logic [31:0] w1,
  output logic [31:0] w2,
  output logic [31:0] w3
);
  timeunit 1ns;
  timeprecision 1ns;
  assign w1 = {3'h0, ep, 1'b0, cat, 12'h000, rx};
  assign w2 = {8'h00, conc, e2e};
  assign w3 = {8'h00, openx, 16'h0000};
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] zero = 32'h0000_0000;
  localparam logic [31:0] ones = 32'hFFFF_FFFF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = zero;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = login_pkg::WORD_SIZE;
  logic [31:0] hwdata = zero;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic login_reject;
  logic [1:0] pe = 2'h0;
  logic [1:0] pc = 2'h0;
  logic [11:0] prx = 12'h100;
  logic [7:0] pn = 8'h01;
  logic [15:0] pk = 16'h0001;
  logic [7:0] px = 8'h00;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [63:0] q[$];
  logic [63:0] nt;
  logic rdp = 1'b0;
  logic [31:0] e;
  logic [31:0] r;
  logic [11:0] rt[6] = '{12'h0FC, 12'h100, 12'h102, 12'h840, 12'h844,
                         12'h204};
  logic [11:0] bt[6] = '{12'h840, 12'h100, 12'h840, 12'h840, 12'h840,
                         12'h200};
  logic [31:0] ct[7] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h31, 32'h11, 32'h4};
  logic [31:0] cx[7] = '{32'h4000_0001, 32'h4000_0002, 32'h8000_0002,
                         32'h0000_0001, 32'h8000_0001, 32'h4000_0002, zero};
  int err_total = 0;
  int comparisons = 0;
  login_param_host login_param_host_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .login_reject(login_reject));
  peer_port peer_port_inst (.ep(pe), .cat(pc), .rx(prx), .conc(pn),
    .e2e(pk), .openx(px), .w1(w1), .w2(w2), .w3(w3));
  initial
    forever #25 hclk = ~hclk;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        report_and_stop();
      end
      @(posedge hclk);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m);
    q.push_back({x & m, m});
    xf(1'b0, a, zero);
  endtask
  task automatic st();
    repeat (3) @(posedge hclk);
  endtask
  task automatic pw(input logic [31:0] x);
    @(posedge hclk);
    wr(login_pkg::ADDR_PEER_W1, w1 | x);
    wr(login_pkg::ADDR_PEER_W2, w2);
    wr(login_pkg::ADDR_PEER_W3, w3);
    st();
  endtask
  always @(posedge hclk)
  begin
    if (rdp && hreadyout === 1'b1)
    begin
      nt = q.pop_front();
      ck(hrdata & nt[31:0], nt[63:32]);
      ck({31'h0, hresp}, zero);
    end
    if (hreadyout === 1'b1)
      rdp = hsel && htrans[1] && !hwrite;
  end
  initial
  begin
    void'($urandom(2967));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(login_pkg::ADDR_CTRL, zero, ones);
    wr(8'h44, ones);
    chk(8'h44, zero, ones);
    wr(login_pkg::ADDR_COMMON, 32'h0000_0840);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      wr(login_pkg::ADDR_CTRL, {27'h0, i[0], 4'h0});
      pe = i[1:0];
      pc = i[3:2];
      prx = 12'h100 + 12'($urandom % 465) * 12'h004;
      pw(zero);
      e = zero;
      e[0] = pe == 2'h2;
      e[1] = e[0] & i[0];
      e[10] = pe[0];
      e[9:8] = pc;
      e[11] = pc == 2'h2;
      e[4] = e[10] | e[11];
      chk(login_pkg::ADDR_STATUS, e, 32'h0000_0F13);
      ck({31'h0, login_reject}, {31'h0, e[4]});
    end
    $display("test codes done");
    pe = 2'h0;
    pc = 2'h0;
    for (int i = 0; i < 6; i++)
    begin
      wr(login_pkg::ADDR_COMMON, {20'h0, bt[i]});
      prx = rt[i];
      pw(zero);
      e = zero;
      e[12] = rt[i] < 12'h100 || rt[i] > 12'h840 || rt[i][1:0] != 2'h0;
      e[13] = rt[i] > bt[i];
      chk(login_pkg::ADDR_STATUS, e, 32'h0000_3000);
      chk(login_pkg::ADDR_SIZES, {20'h0, rt[i]}, 32'h0000_0FFF);
    end
    wr(login_pkg::ADDR_COMMON, 32'h0000_0840);
    prx = 12'h100;
    for (int k = 0; k < 4; k++)
    begin
      wr(login_pkg::ADDR_LOCAL_W1, {13'h0, k[0], 18'h0});
      pw({12'h0, k[0], k[1], 18'h0});
      e = {28'h0, k[0], k[0] & k[1], 2'h0};
      chk(login_pkg::ADDR_STATUS, e, 32'h0000_000C);
    end
    $display("test sizes done");
    for (int k = 0; k < 4; k++)
    begin
      pn = (k == 0) ? 8'h00 : 8'($urandom % 255 + 1);
      pk = (k == 1 || k == 3) ? 16'h0000 : 16'($urandom % 32767 + 1);
      pk = (k == 2) ? 16'h8001 : pk;
      wr(login_pkg::ADDR_CTRL, {28'h0, k == 3, 3'h0});
      pw(zero);
      e = {16'h0, k == 1 || k == 2, pn == 8'h00, 14'h0};
      chk(login_pkg::ADDR_STATUS, e, 32'h0000_C000);
      chk(login_pkg::ADDR_LIMITS, {pn, 8'h00, pk}, 32'hFF00_FFFF);
    end
    pn = 8'h01;
    pk = 16'h0002;
    px = 8'($urandom);
    pw(zero);
    for (int t = 0; t < 6; t++)
    begin
      wr(login_pkg::ADDR_CTRL, 32'(t));
      st();
      e = {8'h00, (t < 2) ? px : 8'h00, 16'h0000};
      chk(login_pkg::ADDR_LIMITS, e, 32'h00FF_0000);
    end
    wr(login_pkg::ADDR_CTRL, zero);
    st();
    e = {7'h0, 9'(px) + 9'h002, 16'h0000};
    chk(login_pkg::ADDR_SIZES, e, 32'h01FF_0000);
    $display("test limits done");
    wr(login_pkg::ADDR_AUX_W0, 32'h8000_0000);
    st();
    chk(login_pkg::ADDR_STATUS, ones, 32'h0001_0000);
    wr(login_pkg::ADDR_AUX_W0, 32'h6000_0000);
    st();
    chk(login_pkg::ADDR_STATUS, zero, 32'h0003_0000);
    r = $urandom;
    wr(login_pkg::ADDR_VV0, r);
    chk(login_pkg::ADDR_VV0, zero, ones);
    wr(login_pkg::ADDR_COMMON, 32'h2000_0840);
    st();
    chk(login_pkg::ADDR_VV0, r, ones);
    chk(login_pkg::ADDR_STATUS, ones, 32'h0002_0000);
    wr(login_pkg::ADDR_CTRL, 32'h0000_0003);
    for (int k = 0; k < 4; k++)
    begin
      r = (k == 0) ? $urandom % 32'h0000_FFFE : 32'h0000_FFFC + 32'(k);
      wr(login_pkg::ADDR_AUX_W3, r);
      st();
      chk(login_pkg::ADDR_NPIV, r, 32'h0000_FFFF);
      e = {12'h0, (k == 0) ? 2'h1 : 2'(k), 18'h0};
      chk(login_pkg::ADDR_STATUS, e, 32'h000C_0000);
    end
    wr(login_pkg::ADDR_CTRL, 32'h0000_0004);
    st();
    chk(login_pkg::ADDR_NPIV, zero, 32'h0000_FFFF);
    chk(login_pkg::ADDR_STATUS, zero, 32'h000C_0000);
    wr(login_pkg::ADDR_CTRL, 32'h0000_0005);
    // a byte-sized write must be ignored
    hsize <= 3'h0;
    wr(login_pkg::ADDR_AUX_W3, zero);
    hsize <= login_pkg::WORD_SIZE;
    st();
    chk(login_pkg::ADDR_STATUS, ones, 32'h000C_0000);
    $display("test aux done");
    pc = 2'h3;
    pw(zero);
    wr(login_pkg::ADDR_CTRL, 32'h0000_0028);
    pc = 2'h1;
    pw(zero);
    wr(login_pkg::ADDR_CTRL, 32'h0000_0020);
    wr(login_pkg::ADDR_CTRL, zero);
    st();
    chk(login_pkg::ADDR_STATUS, 32'h00D0_0000, 32'h00F0_0000);
    for (int k = 0; k < 7; k++)
    begin
      wr(login_pkg::ADDR_CREDIT, ct[k]);
      st();
      chk(login_pkg::ADDR_CREDIT, cx[k], 32'hC000_FFFF);
    end
    wr(login_pkg::ADDR_CTRL, 32'h0000_0008);
    for (int k = 0; k < 3; k++)
    begin
      wr(login_pkg::ADDR_CREDIT, 32'h0000_0001);
      st();
      chk(login_pkg::ADDR_CREDIT, 32'h4000_0000, 32'hC000_FFFF);
    end
    $display("test credit done");
    report_and_stop();
  end
endmodule
`default_nettype wire
